// [hdl/sbst_pkg.sv]
// Package for the SRAM boundary-scan test port: states, instruction codes,
// sizes and the pin-side structs shared by the test port files.
// Assumes a single system clock that oversamples the test clock.
package sbst_pkg;

  localparam int unsigned SBST_IR_W      = 3;
  localparam int unsigned SBST_ID_W      = 32;
  localparam int unsigned SBST_BSR_W     = 8;
  localparam int unsigned SBST_SYNC_W    = 2;
  localparam int unsigned SBST_RESET_TMS = 5;

  localparam logic [2:0] SBST_IR_EXTEST  = 3'h0;
  localparam logic [2:0] SBST_IR_IDCODE  = 3'h1;
  localparam logic [2:0] SBST_IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] SBST_IR_SAMPLE  = 3'h4;
  localparam logic [2:0] SBST_IR_BYPASS  = 3'h7;
  localparam logic [1:0] SBST_IR_CAPTURE = 2'h1;

  // Arbitrary identification value, names no maker or part
  localparam logic [31:0] SBST_ID_CODE   = 32'h0a5a_5001;
  localparam logic        SBST_BYP_RESET = 1'b0;

  typedef enum logic [15:0] {
    SBST_RESET  = 16'h0001,
    SBST_IDLE   = 16'h0002,
    SBST_SEL_DR = 16'h0004,
    SBST_CAP_DR = 16'h0008,
    SBST_SH_DR  = 16'h0010,
    SBST_EX1_DR = 16'h0020,
    SBST_PA_DR  = 16'h0040,
    SBST_EX2_DR = 16'h0080,
    SBST_UP_DR  = 16'h0100,
    SBST_SEL_IR = 16'h0200,
    SBST_CAP_IR = 16'h0400,
    SBST_SH_IR  = 16'h0800,
    SBST_EX1_IR = 16'h1000,
    SBST_PA_IR  = 16'h2000,
    SBST_EX2_IR = 16'h4000,
    SBST_UP_IR  = 16'h8000
  } sbst_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_pins_s;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbst_out_s;

endpackage : sbst_pkg

// [hdl/sbst_sync.sv]
// Two-flop synchroniser bank for the test port pins.
// Inputs arrive from outside the system clock domain.
`timescale 1ns/1ps
module sbst_sync
  import sbst_pkg::*;
#(
  parameter int unsigned      WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             sys_clk_i, // System clock
  input  wire logic             rst_i,     // Synchronous reset
  input  wire logic [WIDTH-1:0] async_i,   // Raw pin levels
  output logic      [WIDTH-1:0] sync_o     // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // Reset value is each pin's idle level, so no false edge follows reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : sbst_sync

// [hdl/sbst_tap.sv]
// Boundary-scan test access port of a pipelined SRAM, oversampled design.
// Assumes sys_clk_i runs at least four times the test clock; pull-ups
// sit in the pad ring, which delivers 1 on an unconnected pin.
`timescale 1ns/1ps

// Functional notes
// (RL1) Inputs taken at test clock rise; outputs change at test clock fall.
// (RL2) Mode select sampled each rise; reads high when left open.
// (RL3) Serial data input reads high when left open.
// (RL4) Serial input enters MSB; LSB drives serial output.
// (RL5) Current instruction picks the register in the serial path.
// (RL6) Only one register sits in the serial path at once.
// (RL7) Serial output driven only in shift states, else high impedance.
// (RL8) Five rises with mode select high reach test-logic reset.
// (RL9) Test reset never disturbs memory operation.
// (RL10) Power-up resets test logic; serial output starts floated.
// (RL11) Unused port: board holds test clock low.
// (RL12) Mode select at each rise decides state transitions.
// (RL13) Three-bit instruction register loaded serially in shift-IR.
// (RL14) Identification instruction loaded at power-up and in reset state.
// (RL15) Capture-IR loads pattern 01 into the two low bits.
// (RL16) One-bit bypass register, forced low under bypass.
// (RL17) Boundary register snapshots I/O ring in capture-DR, shifts it out.
// (RL18) Extest, sample and sample-Z all capture the I/O ring.
// (RL19) Identification instruction captures fixed 32-bit code.
// (RL20) New instruction takes effect only at update-IR.
// (RL21) All-zero instruction acts as sample but floats memory outputs.
// (RL22) Sample-Z selects boundary register and floats memory outputs.
// (RL23) Scanned data never drives memory pins; no preload.
// (RL24) Standard sixteen-state controller.
// (RL25) Instruction codes are parameters; all ones selects bypass. Extest code is fixed, not a parameter; IR_BYP is unused.
module sbst_tap
  import sbst_pkg::*;
#(
  parameter int unsigned   BSR_W   = SBST_BSR_W,
  parameter logic [2:0]    IR_BYP  = SBST_IR_BYPASS, // RL25
  parameter logic [2:0]    IR_ID   = SBST_IR_IDCODE,
  parameter logic [2:0]    IR_SMPZ = SBST_IR_SAMPLEZ,
  parameter logic [2:0]    IR_SMP  = SBST_IR_SAMPLE,
  parameter logic [31:0]   ID_CODE = SBST_ID_CODE
) (
  input  wire logic             sys_clk_i,  // 40 MHz system clock
  input  wire logic             rst_i,      // Power-up reset, active high
  input  wire logic             tck_i,      // Test clock pin
  input  wire logic             tms_i,      // Mode select pin
  input  wire logic             tdi_i,      // Serial data in pin
  input  wire logic [BSR_W-1:0] ring_i,     // I/O ring levels to capture
  output logic                  tdo_o,      // Serial data out
  output logic                  tdo_oe_o,   // Serial out enable
  output logic                  mem_hiz_o,  // Force memory outputs floated
  output sbst_state_e           state_o,    // Controller state
  output logic [SBST_IR_W-1:0]  ir_o        // Instruction in effect
);

  sbst_pins_s  pins_raw;
  sbst_pins_s  pins_s;
  sbst_out_s   out_q;
  sbst_out_s   out_d;

  sbst_state_e          state_q;
  sbst_state_e          state_d;
  logic [SBST_IR_W-1:0] ir_sh_q;
  logic [SBST_IR_W-1:0] ir_sh_d;
  logic [SBST_IR_W-1:0] ir_q;
  logic [SBST_IR_W-1:0] ir_d;
  logic                 byp_q;
  logic                 byp_d;
  logic [SBST_ID_W-1:0] id_q;
  logic [SBST_ID_W-1:0] id_d;
  logic [BSR_W-1:0]     bsr_q;
  logic [BSR_W-1:0]     bsr_d;
  logic [BSR_W-1:0]     ring_q;
  logic                 tck_q;
  logic                 rise;
  logic                 fall;
  logic                 dr_lsb;
  logic                 sel_bsr;
  logic                 sel_id;

  // Idle pin levels: test clock low, open inputs pulled high
  localparam sbst_pins_s PINS_IDLE = '{
    tck: 1'b0,
    tms: 1'b1, // RL2
    tdi: 1'b1  // RL3
  };

  assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i};

  // Pins pass two flops before any logic reads them
  sbst_sync #(
    .WIDTH   (3),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (pins_raw),
    .sync_o    (pins_s)
  );

  assign rise = pins_s.tck & ~tck_q;
  assign fall = ~pins_s.tck & tck_q;

  // Ring snapshot register: ring runs on the memory clock, so capture
  // may be metastable-ish in value; the value is advisory only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tck_q  <= 1'b0;
      ring_q <= '0;
    end else begin
      tck_q  <= pins_s.tck;
      ring_q <= ring_i;
    end
  end

  // Next state, decided by mode select at each test clock rise
  always_comb begin
    state_d = state_q;
    if (rise) begin // RL1 RL12
      case (state_q) // RL24
        SBST_RESET:  state_d = pins_s.tms ? SBST_RESET : SBST_IDLE; // RL8
        SBST_IDLE:   state_d = pins_s.tms ? SBST_SEL_DR : SBST_IDLE;
        SBST_SEL_DR: state_d = pins_s.tms ? SBST_SEL_IR : SBST_CAP_DR;
        SBST_CAP_DR: state_d = pins_s.tms ? SBST_EX1_DR : SBST_SH_DR;
        SBST_SH_DR:  state_d = pins_s.tms ? SBST_EX1_DR : SBST_SH_DR;
        SBST_EX1_DR: state_d = pins_s.tms ? SBST_UP_DR : SBST_PA_DR;
        SBST_PA_DR:  state_d = pins_s.tms ? SBST_EX2_DR : SBST_PA_DR;
        SBST_EX2_DR: state_d = pins_s.tms ? SBST_UP_DR : SBST_SH_DR;
        SBST_UP_DR:  state_d = pins_s.tms ? SBST_SEL_DR : SBST_IDLE;
        SBST_SEL_IR: state_d = pins_s.tms ? SBST_RESET : SBST_CAP_IR;
        SBST_CAP_IR: state_d = pins_s.tms ? SBST_EX1_IR : SBST_SH_IR;
        SBST_SH_IR:  state_d = pins_s.tms ? SBST_EX1_IR : SBST_SH_IR;
        SBST_EX1_IR: state_d = pins_s.tms ? SBST_UP_IR : SBST_PA_IR;
        SBST_PA_IR:  state_d = pins_s.tms ? SBST_EX2_IR : SBST_PA_IR;
        SBST_EX2_IR: state_d = pins_s.tms ? SBST_UP_IR : SBST_SH_IR;
        SBST_UP_IR:  state_d = pins_s.tms ? SBST_SEL_DR : SBST_IDLE;
        default:     state_d = SBST_RESET;
      endcase
    end
  end

  // Data register selection from the instruction in effect
  always_comb begin
    sel_bsr = (ir_q == SBST_IR_EXTEST) || (ir_q == IR_SMP) ||
              (ir_q == IR_SMPZ); // RL5 RL18 RL21 RL22
    sel_id  = (ir_q == IR_ID);
    // Reserved codes fall back to bypass
    if (sel_bsr) begin
      dr_lsb = bsr_q[0];
    end else if (sel_id) begin
      dr_lsb = id_q[0];
    end else begin
      dr_lsb = byp_q;
    end
  end

  // Shift registers, all moved on the test clock rise
  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    byp_d   = byp_q;
    id_d    = id_q;
    bsr_d   = bsr_q;
    if (rise) begin
      case (state_q)
        SBST_RESET: begin
          ir_d    = IR_ID; // RL14
          ir_sh_d = IR_ID;
        end
        SBST_CAP_IR: begin
          ir_sh_d = {ir_q[SBST_IR_W-1:2], SBST_IR_CAPTURE}; // RL15
        end
        SBST_SH_IR: begin
          ir_sh_d = {pins_s.tdi, ir_sh_q[SBST_IR_W-1:1]}; // RL4 RL13
        end
        SBST_CAP_DR: begin
          // Only the selected register captures
          if (sel_bsr) begin
            bsr_d = ring_q; // RL17 RL18
          end else if (sel_id) begin
            id_d = ID_CODE; // RL19
          end else begin
            byp_d = SBST_BYP_RESET; // RL16
          end
        end
        SBST_SH_DR: begin
          if (sel_bsr) begin
            bsr_d = {pins_s.tdi, bsr_q[BSR_W-1:1]}; // RL4 RL6
          end else if (sel_id) begin
            id_d = {pins_s.tdi, id_q[SBST_ID_W-1:1]}; // RL4 RL6
          end else begin
            byp_d = pins_s.tdi; // RL6
          end
        end
        default: begin
        end
      endcase
    end
    if (rise && state_q == SBST_UP_IR) begin
      ir_d = ir_sh_q; // RL20
    end
    // Identification returns as the reset state is entered, not a rise later
    if (rise && state_d == SBST_RESET) begin
      ir_d    = IR_ID; // RL14
      ir_sh_d = IR_ID;
    end
  end

  // Serial out updated only on the test clock fall
  always_comb begin
    out_d = out_q;
    if (fall) begin // RL1
      out_d.tdo_oe = (state_q == SBST_SH_DR) || (state_q == SBST_SH_IR); // RL7
      out_d.tdo    = (state_q == SBST_SH_IR) ? ir_sh_q[0] : dr_lsb; // RL4
    end
  end

  // Synchronous reset serves as the power-up reset of the port
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin // RL10
      state_q <= SBST_RESET;
      ir_sh_q <= IR_ID;
      ir_q    <= IR_ID; // RL14
      byp_q   <= SBST_BYP_RESET;
      id_q    <= ID_CODE;
      bsr_q   <= '0;
      out_q   <= '{tdo: 1'b0, tdo_oe: 1'b0}; // RL10
    end else begin
      state_q <= state_d;
      ir_sh_q <= ir_sh_d;
      ir_q    <= ir_d;
      byp_q   <= byp_d;
      id_q    <= id_d;
      bsr_q   <= bsr_d;
      out_q   <= out_d;
    end
  end

  assign tdo_o     = out_q.tdo;
  assign tdo_oe_o  = out_q.tdo_oe;
  // Scanned data never reaches memory pins; only the float request does
  assign mem_hiz_o = (ir_q == SBST_IR_EXTEST) ||
                     (ir_q == IR_SMPZ); // RL9 RL21 RL22 RL23
  assign state_o   = state_q;
  assign ir_o      = ir_q;

endmodule : sbst_tap

// [test/sbst_tap_sva.sv]
// Checker: output timing and state relations at the scan port pins.
// Assumes the test clock is at least four times slower than sys_clk_i.
`timescale 1ns/1ps
module sbst_tap_sva
  import sbst_pkg::*;
(
  input wire logic                 sys_clk_i, // Clock
  input wire logic                 rst_i,     // Reset
  input wire logic                 tck_i,     // Test clock
  input wire logic                 tms_i,     // Mode select
  input wire logic                 tdo_o,     // Serial out
  input wire logic                 tdo_oe_o,  // Out enable
  input wire logic                 mem_hiz_o, // Memory float
  input wire sbst_state_e          state_o,   // State
  input wire logic [SBST_IR_W-1:0] ir_o       // Instruction
);
  logic       tck_q;
  logic       rise;
  logic [3:0] rise_n;
  logic [3:0] fall_n;
  logic [3:0] ones_n;
  assign rise = tck_i && !tck_q;
  // Cycles since each test clock edge, saturating
  always_ff @(posedge sys_clk_i) begin
    tck_q  <= tck_i;
    rise_n <= (rst_i || rise) ? 4'h0 : rise_n + 4'(rise_n != 4'hf);
    fall_n <= (rst_i || !tck_i && tck_q) ? 4'h0 : fall_n + 4'(fall_n != 4'hf);
    if (rst_i || rise)
      ones_n <= (tms_i && !rst_i) ? ones_n + 4'(ones_n != 4'h5) : 4'h0;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_out_fall; $changed({tdo_o, tdo_oe_o}) |-> fall_n <= 4'h5;
  endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("serial out moved away from a clock fall");
  property p_st_rise; $changed(state_o) |-> rise_n <= 4'h5; endproperty
  a_st_rise: assert property (p_st_rise)
    else $error("state moved away from a clock rise");
  property p_oe_shift; tdo_oe_o |->
    state_o inside {SBST_SH_DR, SBST_SH_IR, SBST_EX1_DR, SBST_EX1_IR};
  endproperty
  a_oe_shift: assert property (p_oe_shift)
    else $error("serial out driven outside a shift");
  property p_five; rise && tms_i && ones_n >= 4'h4 |->
    ##[1:6] state_o == SBST_RESET; endproperty
  a_five: assert property (p_five)
    else $error("five high mode selects did not reset");
  property p_ir_upd; $changed(ir_o) |->
    $past(state_o) == SBST_UP_IR || state_o == SBST_RESET; endproperty
  a_ir_upd: assert property (p_ir_upd)
    else $error("instruction changed outside update");
  property p_ir_rst; state_o == SBST_RESET |-> ir_o == SBST_IR_IDCODE;
  endproperty
  a_ir_rst: assert property (p_ir_rst)
    else $error("reset state without identification code");
  property p_hiz;
    mem_hiz_o == (ir_o == SBST_IR_EXTEST || ir_o == SBST_IR_SAMPLEZ);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("memory float flag wrong");
  property p_capir; $rose(tdo_oe_o) && state_o == SBST_SH_IR |-> tdo_o;
  endproperty
  a_capir: assert property (p_capir)
    else $error("first instruction bit out not 1");
  c_upd: cover property (state_o == SBST_UP_IR);
  c_byp: cover property (tdo_oe_o && ir_o == SBST_IR_BYPASS);
  c_five: cover property (rise && tms_i && ones_n == 4'h4);
endmodule : sbst_tap_sva
bind sbst_tap sbst_tap_sva u_sva (.sys_clk_i, .rst_i, .tck_i, .tms_i,
  .tdo_o, .tdo_oe_o, .mem_hiz_o, .state_o, .ir_o);

// [test/sbst_ctl_model.sv]
// Scan controller model: drives test clock, mode select and serial in.
// Test clock stands low between steps; one step is eight system clocks.
`timescale 1ns/1ps
module sbst_ctl_model (
  input  wire logic clk_i,    // System clock, paces each step
  output logic      tck_o,    // Test clock
  output logic      tms_o,    // Mode select
  output logic      tdi_o,    // Serial data in
  input  wire logic tdo_i,    // Serial data out
  input  wire logic tdo_oe_i  // Serial out enable
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // Called at a system clock rise; pins move by non-blocking assignment
  task automatic step(input logic m, input logic d, output logic o,
                      output logic e);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    o = tdo_i;
    e = tdo_oe_i;
    tck_o <= 1'b0;
  endtask : step
endmodule : sbst_ctl_model

// [test/sbst_tap_tb_top.sv]
// Testbench: loads every instruction and scans against a reference model.
// Assumes sbst_ctl_model makes all test port pin traffic.
`timescale 1ns/1ps
module sbst_tap_tb_top;
  import sbst_pkg::*;
  logic                  clk;
  logic                  rst;
  logic                  tck, tms, tdi, tdo, oe, hiz, o, e;
  logic [SBST_BSR_W-1:0] ring;
  logic [SBST_IR_W-1:0]  ir;
  logic [2:0]            ref_ir;
  sbst_state_e           st;
  int                    bad_count;
  int                    n_compared;
  sbst_tap dut (.sys_clk_i(clk), .rst_i(rst), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .ring_i(ring), .tdo_o(tdo), .tdo_oe_o(oe),
    .mem_hiz_o(hiz), .state_o(st), .ir_o(ir));
  sbst_ctl_model ctl (.clk_i(clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo), .tdo_oe_i(oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic tk(input logic m, input logic d);
    ctl.step(m, d, o, e);
  endtask : tk
  task automatic ir_load(input logic [2:0] c);
    for (int k = 0; k < 4; k++) tk(k < 2, 1'b1);
    for (int k = 0; k < 3; k++) begin
      tk(k == 2, c[k]);
      check(o, k == 0 ? 1'b1 : k == 1 ? 1'b0 : ref_ir[2]);
      check(e, 1'b1);
    end
    check(ir, ref_ir);
    tk(1'b1, 1'b1);
    check(e, 1'b0);
    tk(1'b0, 1'b1);
    ref_ir = c;
    check(ir, c);
    check(hiz, c == SBST_IR_EXTEST || c == SBST_IR_SAMPLEZ);
  endtask : ir_load
  task automatic dr_scan;
    logic [39:0] cap;
    logic [39:0] din;
    int          len;
    logic        exp_q[$];
    din = {8'($urandom), $urandom};
    len = ref_ir == SBST_IR_IDCODE ? 32 : ref_ir inside {SBST_IR_EXTEST,
      SBST_IR_SAMPLEZ, SBST_IR_SAMPLE} ? int'(SBST_BSR_W) : 1;
    cap = ref_ir == SBST_IR_IDCODE ? 40'(SBST_ID_CODE) : 40'(ring);
    if (len == 1)
      cap = 40'h0;
    // Expected serial stream: captured bits first, then what was shifted in
    for (int k = 0; k < len; k++)
      exp_q.push_back(cap[k]);
    for (int k = 0; k < 40; k++)
      exp_q.push_back(din[k]);
    tk(1'b1, 1'b1);
    tk(1'b0, 1'b1);
    tk(1'b0, 1'b1);
    // Ring moves after capture, so only the snapshot may come out
    @(posedge clk);
    ring <= (SBST_BSR_W)'($urandom);
    for (int k = 0; k < 40; k++) begin
      tk(k == 39, din[k]);
      check(o, exp_q.pop_front());
      check(e, 1'b1);
    end
    tk(1'b1, 1'b1);
    check(e, 1'b0);
    tk(1'b0, 1'b1);
  endtask : dr_scan
  initial begin
    #2000000;
    bad_count++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    ring = '0;
    bad_count = 0;
    n_compared = 0;
    ref_ir = SBST_IR_IDCODE;
    void'($urandom(65722));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(st, SBST_RESET);
    check(oe, 1'b0);
    check(ir, SBST_IR_IDCODE);
    $display("power-up test done");
    tk(1'b0, 1'b1);
    dr_scan;
    for (int c = 0; c < 8; c++) begin
      ir_load(3'(c));
      dr_scan;
      $display("instruction %0d test done", c);
    end
    for (int k = 0; k < 3; k++) tk(k == 0, 1'b1);
    for (int k = 0; k < 4; k++) tk(1'b1, 1'b1);
    check(st, SBST_SEL_IR);
    tk(1'b1, 1'b1);
    check(st, SBST_RESET);
    check(ir, SBST_IR_IDCODE);
    ref_ir = SBST_IR_IDCODE;
    $display("five-high reset test done");
    for (int k = 0; k < 5; k++) tk(k == 1, 1'b1);
    check(e, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(oe, 1'b0);
    check(st, SBST_RESET);
    tk(1'b0, 1'b1);
    dr_scan;
    $display("mid-run reset test done");
    complete_run;
  end
endmodule : sbst_tap_tb_top
